// ---- verilog/nbaop_pkg.sv ----
// constants, types and decoding shared by the protection block
// assumes a serial host sending opcode, feature address and data bytes msb first
package nbaop_pkg;

    // ============================================================
    // feature addresses and opcodes
    localparam logic [7:0] FEAT_PROT_ADDR  = 8'hA0;
    localparam logic [7:0] FEAT_CFG_ADDR   = 8'hB0;
    localparam logic [7:0] FEAT_STAT_ADDR  = 8'hC0;
    localparam logic [7:0] OP_SET_FEAT     = 8'h1F;
    localparam logic [7:0] OP_GET_FEAT     = 8'h0F;
    localparam logic [7:0] OP_PROG_EXEC    = 8'h10;
    localparam logic [7:0] OP_ERASE        = 8'hD8;
    localparam logic [7:0] OP_PAGE_READ    = 8'h13;
    localparam logic [7:0] OP_RESET        = 8'hFF;
    localparam logic [7:0] OP_LOAD_X4      = 8'h32;
    localparam logic [7:0] OP_LOAD_X4_RAND = 8'h34;

    // ============================================================
    // field positions
    localparam int PR_PROTECT_WRITE_DISABLE_BIT  = 7;
    localparam int PR_LEVEL_MSB  = 6;
    localparam int PR_LEVEL_LSB  = 3;
    localparam int PR_TB_BIT     = 2;
    localparam int PR_WPE_BIT    = 1;
    localparam int PR_SP_BIT     = 0;
    localparam int CR_OTPP_BIT   = 7;
    localparam int CR_OTPE_BIT   = 6;
    localparam int CR_PRL_BIT    = 5;
    localparam int CR_ECC_BIT    = 4;
    localparam int CR_HD_BIT     = 0;
    localparam int SR_PFAIL_BIT  = 3;
    localparam int SR_EFAIL_BIT  = 2;
    localparam int ROW_BITS      = 17;
    localparam int OTP_PAGES     = 30;

    // ============================================================
    // reset values and limits
    localparam logic [7:0]  PR_RESET        = 8'h7C;
    localparam logic [7:0]  CR_RESET        = 8'h10;
    localparam logic [7:0]  SR_RESET        = 8'h00;
    localparam logic [3:0]  SYNC_RESET      = 4'h7;
    localparam logic [3:0]  LEVEL_MAX       = 4'hA;
    localparam logic [10:0] BLK_ALL_ONES    = 11'h7FF;
    localparam logic [5:0]  OTP_PAGE_COUNT  = 6'h1E;
    localparam logic [7:0]  SPARE_ECC_ON    = 8'h40;
    localparam logic [7:0]  SPARE_ECC_OFF   = 8'h80;
    localparam logic [2:0]  SETF_BYTES      = 3'h3;
    localparam logic [2:0]  ADDR_CMD_BYTES  = 3'h4;
    localparam logic [2:0]  MAX_BYTES       = 3'h4;
    localparam logic [2:0]  QUAD_ADDR_BYTES = 3'h2;

    typedef enum logic [1:0] {
        OTPM_NORMAL,
        OTPM_ACCESS,
        OTPM_UNDEF,
        OTPM_LOCK
    } nbaop_otp_mode_t;

    // ============================================================
    // locked range: the block index shifted by the level is all ones (top) or zero (bottom); level 0 locks nothing
    function automatic logic nbaop_blk_locked(input logic [3:0]  level,
                                              input logic        tb,
                                              input logic [10:0] blk);
        logic [10:0] hi;
        logic [10:0] ones;
        hi   = blk >> level;
        ones = BLK_ALL_ONES >> level;
        if (level == 4'h0) begin
            return 1'b0;
        end
        if (level > LEVEL_MAX) begin
            return 1'b1;
        end
        return tb ? (hi == 11'h000) : (hi == ones);
    endfunction

endpackage

// ---- verilog/nbaop_link.sv ----
// serial front end on the host clock: collects command bytes, returns feature reads
// assumes mode 0 timing and that the frame bytes stay put while chip select is high
`timescale 1ns/1ps
module nbaop_link (
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_prot_val,
    input  wire logic [7:0] i_cfg_val,
    input  wire logic [7:0] i_stat_val,
    output logic [7:0]      o_opcode,
    output logic [7:0]      o_arg1,
    output logic [7:0]      o_arg2,
    output logic [7:0]      o_arg3,
    output logic [2:0]      o_nbytes,
    output logic            o_quad_data,
    output logic            o_miso,
    output logic            o_miso_oe
);
    import nbaop_pkg::*;

    logic       fresh_r;
    logic [2:0] bitcnt_r;
    logic [6:0] shift_r;
    logic [2:0] count_now;
    logic [7:0] byte_in;
    logic [7:0] read_sel;

    assign count_now = fresh_r ? 3'h0 : o_nbytes;
    assign byte_in   = {shift_r, i_mosi};

    always_comb begin
        read_sel = 8'h00;
        if (o_arg1 == FEAT_PROT_ADDR) begin
            read_sel = i_prot_val;
        end else if (o_arg1 == FEAT_CFG_ADDR) begin
            read_sel = i_cfg_val;
        end else if (o_arg1 == FEAT_STAT_ADDR) begin
            read_sel = i_stat_val;
        end
    end

    // ============================================================
    // bit counter, cleared while chip select is high
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            fresh_r     <= 1'b1;
            bitcnt_r    <= 3'h0;
            o_quad_data <= 1'b0;
        end else begin
            fresh_r  <= 1'b0;
            bitcnt_r <= bitcnt_r + 3'h1;
            if (bitcnt_r == 3'h7 && count_now == QUAD_ADDR_BYTES &&
                (o_opcode == OP_LOAD_X4 || o_opcode == OP_LOAD_X4_RAND)) begin
                o_quad_data <= 1'b1;
            end
        end
    end

    // ============================================================
    // byte capture, kept after the frame ends
    always_ff @(posedge i_sclk) begin
        shift_r <= byte_in[6:0];
        if (bitcnt_r == 3'h7) begin
            unique case (count_now)
                3'h0: o_opcode <= byte_in;
                3'h1: o_arg1 <= byte_in;
                3'h2: o_arg2 <= byte_in;
                3'h3: o_arg3 <= byte_in;
                default: begin
                end
            endcase
            if (count_now != MAX_BYTES) begin
                o_nbytes <= count_now + 3'h1;
            end
        end else if (fresh_r) begin
            o_nbytes <= 3'h0;
        end
    end

    // ============================================================
    // feature read data, shifted out on the falling edge
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_miso    <= 1'b0;
            o_miso_oe <= 1'b0;
        end else if (!fresh_r && o_opcode == OP_GET_FEAT && o_nbytes >= 3'h2) begin
            o_miso_oe <= 1'b1;
            o_miso    <= read_sel[~bitcnt_r];
        end
    end

endmodule

// ---- verilog/nbaop_core.sv ----
// write protection, block lock decode and one-time area control of a serial nand
// assumes an array engine that acts on the request pulses and a host on the serial pins
`timescale 1ns/1ps
module nbaop_core (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset,
    input  wire logic                          i_sclk,
    input  wire logic                          i_cs_n,
    input  wire logic                          i_mosi,
    input  wire logic                          i_wp_n,
    input  wire logic                          i_hold_n,
    output logic                               o_miso,
    output logic                               o_miso_oe,
    output logic                               o_prog_req,
    output logic                               o_erase_req,
    output logic                               o_read_req,
    output logic                               o_target_otp,
    output logic [nbaop_pkg::ROW_BITS-1:0]     o_row_addr,
    output logic                               o_prog_fail,
    output logic                               o_erase_fail,
    output logic                               o_ecc_enable,
    output logic [7:0]                         o_spare_bytes,
    output logic                               o_otp_locked,
    output logic                               o_pause_active,
    output logic [7:0]                         o_prot_value,
    output logic [7:0]                         o_cfg_value
);
    import nbaop_pkg::*;

    logic [7:0]          prot_r;
    logic [7:0]          cfg_r;
    logic [3:0]          sync1_r;
    logic [3:0]          sync2_r;
    logic                cs_prev_r;
    logic [OTP_PAGES-1:0] page_done_r;
    logic [7:0]          lk_opcode;
    logic [7:0]          lk_arg1;
    logic [7:0]          lk_arg2;
    logic [7:0]          lk_arg3;
    logic [2:0]          lk_nbytes;
    logic                lk_quad;
    logic                cs_s;
    logic                wp_s;
    logic                hold_s;
    logic                quad_s;
    logic                frame_end;
    logic                wp_low;
    logic                hw_lock;
    logic                bp_frozen;
    logic [ROW_BITS-1:0] row;
    logic [10:0]         blk;
    logic [5:0]          page;
    logic                is_setf;
    logic                is_prog;
    logic                is_erase;
    logic                is_read;
    logic                is_reset;
    logic                lock_hit;
    logic                otp_page_ok;
    logic                prog_go;
    logic                prog_bad;
    logic                lock_go;
    logic                erase_go;
    logic                erase_bad;
    logic [7:0]          stat_val;
    nbaop_otp_mode_t     otp_mode;

    // ============================================================
    // serial front end on the host clock
    nbaop_link u_link (
        .i_sclk      (i_sclk),
        .i_cs_n      (i_cs_n),
        .i_mosi      (i_mosi),
        .i_prot_val  (prot_r),
        .i_cfg_val   (cfg_r),
        .i_stat_val  (stat_val),
        .o_opcode    (lk_opcode),
        .o_arg1      (lk_arg1),
        .o_arg2      (lk_arg2),
        .o_arg3      (lk_arg3),
        .o_nbytes    (lk_nbytes),
        .o_quad_data (lk_quad),
        .o_miso      (o_miso),
        .o_miso_oe   (o_miso_oe)
    );

    // ============================================================
    // pin synchronisers and end of frame
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1_r   <= SYNC_RESET;
            sync2_r   <= SYNC_RESET;
            cs_prev_r <= 1'b1;
        end else begin
            sync1_r   <= {lk_quad, i_hold_n, i_wp_n, i_cs_n};
            sync2_r   <= sync1_r;
            cs_prev_r <= sync2_r[0];
        end
    end

    assign cs_s      = sync2_r[0];
    assign wp_s      = sync2_r[1];
    assign hold_s    = sync2_r[2];
    assign quad_s    = sync2_r[3];
    assign frame_end = cs_s & ~cs_prev_r;

    // ============================================================
    // decode of the captured frame and protection state
    assign wp_low    = ~wp_s & ~cfg_r[CR_HD_BIT];
    assign hw_lock   = prot_r[PR_WPE_BIT] & wp_low;
    assign bp_frozen = prot_r[PR_SP_BIT] | (prot_r[PR_PROTECT_WRITE_DISABLE_BIT] & wp_low);
    assign otp_mode  = nbaop_otp_mode_t'(cfg_r[CR_OTPP_BIT:CR_OTPE_BIT]);
    assign row       = {lk_arg1[0], lk_arg2, lk_arg3};
    assign blk       = row[ROW_BITS-1:6];
    assign page      = row[5:0];
    assign is_setf   = lk_opcode == OP_SET_FEAT && lk_nbytes >= SETF_BYTES;
    assign is_prog   = lk_opcode == OP_PROG_EXEC && lk_nbytes == ADDR_CMD_BYTES;
    assign is_erase  = lk_opcode == OP_ERASE && lk_nbytes == ADDR_CMD_BYTES;
    assign is_read   = lk_opcode == OP_PAGE_READ && lk_nbytes == ADDR_CMD_BYTES;
    assign is_reset  = lk_opcode == OP_RESET && lk_nbytes != 3'h0;
    assign lock_hit  = nbaop_blk_locked(prot_r[PR_LEVEL_MSB:PR_LEVEL_LSB],
                                        prot_r[PR_TB_BIT], blk);
    assign otp_page_ok = page < OTP_PAGE_COUNT && !page_done_r[page[4:0]]
                         && !o_otp_locked;

    always_comb begin
        prog_go  = 1'b0;
        prog_bad = 1'b0;
        lock_go  = 1'b0;
        unique case (otp_mode)
            OTPM_NORMAL: begin
                prog_bad = hw_lock | lock_hit;
                prog_go  = ~prog_bad;
            end
            OTPM_ACCESS: begin
                prog_bad = hw_lock | ~otp_page_ok;
                prog_go  = ~prog_bad;
            end
            OTPM_UNDEF: begin
                prog_bad = 1'b1;
            end
            OTPM_LOCK: begin
                prog_bad = hw_lock;
                lock_go  = ~hw_lock;
            end
        endcase
        erase_bad = hw_lock | lock_hit | (otp_mode != OTPM_NORMAL);
        erase_go  = ~erase_bad;
    end

    always_comb begin
        stat_val               = SR_RESET;
        stat_val[SR_PFAIL_BIT] = o_prog_fail;
        stat_val[SR_EFAIL_BIT] = o_erase_fail;
    end

    // ============================================================
    // write protection settings register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prot_r <= PR_RESET;
        end else if (frame_end && is_setf && lk_arg1 == FEAT_PROT_ADDR &&
                     !cfg_r[CR_PRL_BIT] && !hw_lock) begin
            prot_r[PR_PROTECT_WRITE_DISABLE_BIT] <= lk_arg2[PR_PROTECT_WRITE_DISABLE_BIT];
            if (!bp_frozen) begin
                prot_r[PR_LEVEL_MSB:PR_TB_BIT] <= lk_arg2[PR_LEVEL_MSB:PR_TB_BIT];
            end
            if (!prot_r[PR_SP_BIT]) begin
                prot_r[PR_WPE_BIT] <= lk_arg2[PR_WPE_BIT];
            end
            prot_r[PR_SP_BIT] <= prot_r[PR_SP_BIT] | lk_arg2[PR_SP_BIT];
        end
    end

    // ============================================================
    // feature configuration register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cfg_r <= CR_RESET;
        end else if (frame_end && is_reset) begin
            cfg_r[CR_OTPE_BIT] <= 1'b0;
        end else if (frame_end && is_setf && lk_arg1 == FEAT_CFG_ADDR && !hw_lock) begin
            cfg_r[CR_OTPP_BIT] <= lk_arg2[CR_OTPP_BIT];
            cfg_r[CR_OTPE_BIT] <= lk_arg2[CR_OTPE_BIT];
            cfg_r[CR_ECC_BIT]  <= lk_arg2[CR_ECC_BIT];
            cfg_r[CR_PRL_BIT]  <= cfg_r[CR_PRL_BIT] | (lk_arg2[CR_PRL_BIT] &
                                  prot_r[PR_SP_BIT] & prot_r[PR_PROTECT_WRITE_DISABLE_BIT]);
            if (!prot_r[PR_WPE_BIT]) begin
                cfg_r[CR_HD_BIT] <= lk_arg2[CR_HD_BIT];
            end
        end
    end

    // ============================================================
    // array requests
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prog_req   <= 1'b0;
            o_erase_req  <= 1'b0;
            o_read_req   <= 1'b0;
            o_target_otp <= 1'b0;
            o_row_addr   <= '0;
        end else begin
            o_prog_req  <= frame_end & is_prog & prog_go;
            o_erase_req <= frame_end & is_erase & erase_go;
            o_read_req  <= frame_end & is_read;
            if (frame_end && (is_prog || is_erase || is_read)) begin
                o_row_addr   <= row;
                o_target_otp <= cfg_r[CR_OTPE_BIT];
            end
        end
    end

    // ============================================================
    // failure flags
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prog_fail  <= 1'b0;
            o_erase_fail <= 1'b0;
        end else if (frame_end) begin
            if (is_reset) begin
                o_prog_fail  <= 1'b0;
                o_erase_fail <= 1'b0;
            end else if (is_prog) begin
                o_prog_fail <= prog_bad;
            end else if (is_erase) begin
                o_erase_fail <= erase_bad;
            end
        end
    end

    // ============================================================
    // one-time area page tracking and lock
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            page_done_r  <= '0;
            o_otp_locked <= 1'b0;
        end else if (frame_end && is_prog) begin
            if (prog_go && otp_mode == OTPM_ACCESS) begin
                page_done_r[page[4:0]] <= 1'b1;
            end
            if (lock_go) begin
                o_otp_locked <= 1'b1;
            end
        end
    end

    // ============================================================
    // pause pin, ecc and spare size
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pause_active <= 1'b0;
            o_spare_bytes  <= SPARE_ECC_ON;
        end else begin
            o_pause_active <= ~hold_s & (prot_r[PR_WPE_BIT] | ~cfg_r[CR_HD_BIT])
                              & ~quad_s;
            o_spare_bytes  <= cfg_r[CR_ECC_BIT] ? SPARE_ECC_ON : SPARE_ECC_OFF;
        end
    end

    assign o_ecc_enable = cfg_r[CR_ECC_BIT];
    assign o_prot_value = prot_r;
    assign o_cfg_value  = cfg_r;

    // ============================================================
    // assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    AST_POWERUP_LOCK: assert property (
        $past(i_reset) |-> prot_r[PR_LEVEL_MSB:PR_LEVEL_LSB] == 4'hF && o_ecc_enable
                           && !cfg_r[CR_OTPE_BIT])
        else $error("power-up defaults wrong");
    AST_LOCKED_PROG: assert property (
        frame_end && is_prog && otp_mode == OTPM_NORMAL && lock_hit
        |=> o_prog_fail && !o_prog_req)
        else $error("program into locked block not refused");
    AST_LOCKED_ERASE: assert property (
        frame_end && is_erase && lock_hit |=> o_erase_fail && !o_erase_req)
        else $error("erase into locked block not refused");
    AST_WP_FREEZE: assert property (
        prot_r[PR_PROTECT_WRITE_DISABLE_BIT] && wp_low |=> $stable(prot_r[PR_LEVEL_MSB:PR_TB_BIT]))
        else $error("level changed under write disable");
    AST_SOLID_FREEZE: assert property (
        prot_r[PR_SP_BIT] |=> $stable(prot_r[PR_LEVEL_MSB:PR_WPE_BIT]) && prot_r[PR_SP_BIT])
        else $error("solid lock did not hold");
    AST_PERMALOCK: assert property (
        cfg_r[CR_PRL_BIT] |=> $stable(prot_r) && cfg_r[CR_PRL_BIT])
        else $error("protection changed under permanent lock");
    AST_PERMALOCK_GATE: assert property (
        $rose(cfg_r[CR_PRL_BIT]) |-> $past(prot_r[PR_SP_BIT] & prot_r[PR_PROTECT_WRITE_DISABLE_BIT]))
        else $error("permanent lock set without solid lock and write disable");
    AST_PAUSE_DIS_GATE: assert property (
        $rose(cfg_r[CR_HD_BIT]) |-> !$past(prot_r[PR_WPE_BIT]))
        else $error("pause disable set with hardware protect on");
    AST_SPARE_SIZE: assert property (
        $fell(cfg_r[CR_ECC_BIT]) |=> o_spare_bytes == SPARE_ECC_OFF)
        else $error("spare size not widened");
    AST_OTP_NO_ERASE: assert property (
        frame_end && is_erase && cfg_r[CR_OTPE_BIT] |=> o_erase_fail && !o_erase_req)
        else $error("erase reached one-time area");
    AST_OTP_ONCE: assert property (
        frame_end && is_prog && otp_mode == OTPM_ACCESS && page_done_r[page[4:0]]
        |=> o_prog_fail && !o_prog_req)
        else $error("one-time page programmed twice");
    AST_HW_LOCK: assert property (
        frame_end && hw_lock |=> !o_prog_req && !o_erase_req && $stable(prot_r))
        else $error("write passed hardware protect");
    AST_OTP_READ: assert property (
        frame_end && is_read && cfg_r[CR_OTPE_BIT] |=> o_read_req && o_target_otp)
        else $error("read not steered to one-time area");
    AST_QUAD_PAUSE: assert property (
        quad_s |=> !o_pause_active)
        else $error("pause honoured during quad data");

endmodule

// ---- bench/nbaop_host_model.sv ----
// host serial model: mode 0 frames, msb first
// assumes the core samples mosi on sclk rising and acts when chip select rises
`timescale 1ns/1ps
module nbaop_host_model (
    input  wire logic i_miso,
    input  wire logic i_oe,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_mosi,
    output logic [7:0] o_rx
);
    // chip select rises after time zero so the link's asynchronous clear is seen
    initial begin
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_rx   = 8'h00;
        #1;
        o_cs_n = 1'b1;
    end
    // ============================================================
    // one frame of n bits; clock still and data inverted between frames
    task automatic send(input logic [31:0] bits, input int n);
        #37 o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_mosi = bits[i];
            #80 o_sclk = 1'b1;
            o_rx = {o_rx[6:0], i_oe ? i_miso : 1'bx};
            #80 o_sclk = 1'b0;
        end
        #80 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #200;
    endtask
endmodule

// ---- bench/tb_nbaop_core.sv ----
// self-checking bench for the protection core with a host model on the serial pins
// assumes results settle within 200 ns plus eight core clocks after chip select rises
`timescale 1ns/1ps
module tb_nbaop_core;
    import nbaop_pkg::*;
    logic i_clk, i_reset, i_wp_n, sclk, cs_n, mosi, miso, oe, prq, erq, rrq, tgt, pf, ef;
    logic ecc, otl, pau, lk, tb, hold_n;
    logic [16:0] row;
    logic [7:0] spr, prv, cfv, rx;
    logic [3:0] sel_q[$];
    logic [7:0] exp_q[$];
    int miscompares = 0, check_count = 0, preq_cnt = 0, epreq = 0, span, blk;
    int ereq_cnt = 0, rreq_cnt = 0, eereq = 0, erreq = 0;
    integer seed = 32'h6356_cc7c;
    event chk_ev;
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    nbaop_host_model i_host (.i_miso(miso), .i_oe(oe), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi), .o_rx(rx));
    nbaop_core i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .i_wp_n(i_wp_n), .i_hold_n(hold_n), .o_miso(miso), .o_miso_oe(oe),
        .o_prog_req(prq), .o_erase_req(erq), .o_read_req(rrq), .o_target_otp(tgt),
        .o_row_addr(row), .o_prog_fail(pf), .o_erase_fail(ef), .o_ecc_enable(ecc),
        .o_spare_bytes(spr), .o_otp_locked(otl), .o_pause_active(pau),
        .o_prot_value(prv), .o_cfg_value(cfv));
    always @(posedge i_clk) begin
        if (prq === 1'b1) preq_cnt <= preq_cnt + 1;
        if (erq === 1'b1) ereq_cnt <= ereq_cnt + 1;
        if (rrq === 1'b1) rreq_cnt <= rreq_cnt + 1;
    end
    // ============================================================
    // monitor: oldest note against the output it names
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] obs(input logic [3:0] s);
        case (s)
            0: return prv;
            1: return cfv;
            2: return {7'h0, pf};
            3: return {7'h0, ef};
            4: return spr;
            5: return {7'h0, otl};
            7: return {7'h0, tgt};
            8: return {7'h0, ecc};
            9: return row[7:0];
            10: return row[16:9];
            11: return ereq_cnt[7:0];
            12: return rreq_cnt[7:0];
            13: return {7'h0, pau};
            14: return rx;
            default: return preq_cnt[7:0];
        endcase
    endfunction
    always begin
        @(chk_ev);
        while (sel_q.size() > 0) check(obs(sel_q.pop_front()), exp_q.pop_front());
    end
    // ============================================================
    // driver tasks
    task automatic ex(input logic [3:0] s, input logic [7:0] v);
        sel_q.push_back(s);
        exp_q.push_back(v);
    endtask
    task automatic frame(input logic [31:0] b, input int n);
        i_host.send(b, n);
        repeat (8) @(posedge i_clk);
        -> chk_ev;
        @(posedge i_clk);
    endtask
    task automatic setf(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        ex(a == FEAT_PROT_ADDR ? 4'h0 : 4'h1, e);
        frame({8'h00, OP_SET_FEAT, a, d}, 24);
    endtask
    task automatic op(input logic [7:0] c, input logic [16:0] r, input logic [3:0] s,
                      input logic f);
        if (c == OP_PROG_EXEC && !f) epreq++;
        if (c == OP_ERASE && !f) eereq++;
        if (c == OP_PAGE_READ) erreq++;
        ex(s, {7'h0, f});
        ex(6, epreq[7:0]);
        ex(9, r[7:0]);
        ex(10, r[16:9]);
        ex(11, eereq[7:0]);
        ex(12, erreq[7:0]);
        frame({c, 7'h00, r}, 32);
    endtask
    task automatic results;
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        results();
    end
    initial begin
        i_reset = 1'b1;
        i_wp_n = 1'b1;
        hold_n = 1'b1;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_clk);
        ex(0, 8'h7C);
        ex(1, CR_RESET);
        ex(4, SPARE_ECC_ON);
        ex(8, 8'h01);
        op(OP_PROG_EXEC, 17'h1_FFC0, 2, 1);
        for (int k = 0; k < 13; k++) begin
            tb = $random(seed);
            span = 1 << k;
            blk = $random(seed);
            blk = k > 10 ? blk & 2047 : tb ? span - blk[0] : 2048 - span - blk[0];
            lk = k == 0 ? 0 : k > 10 ? 1 : tb ? blk < span : blk >= 2048 - span;
            setf(FEAT_PROT_ADDR, {1'b0, k[3:0], tb, 2'b00}, {1'b0, k[3:0], tb, 2'b00});
            op(k[0] ? OP_ERASE : OP_PROG_EXEC, {blk[10:0], 6'h00}, k[0] ? 3 : 2, lk);
        end
        setf(FEAT_PROT_ADDR, 8'h80, 8'h80);
        i_wp_n <= 1'b0;
        setf(FEAT_PROT_ADDR, 8'h98, 8'h80);
        i_wp_n <= 1'b1;
        setf(FEAT_PROT_ADDR, 8'h01, 8'h01);
        setf(FEAT_PROT_ADDR, 8'h7E, 8'h01);
        setf(FEAT_CFG_ADDR, 8'h20, 8'h00);
        ex(4, SPARE_ECC_OFF);
        ex(8, 8'h00);
        setf(FEAT_PROT_ADDR, 8'h81, 8'h81);
        setf(FEAT_CFG_ADDR, 8'h20, 8'h20);
        setf(FEAT_PROT_ADDR, 8'h00, 8'h81);
        setf(FEAT_CFG_ADDR, 8'h50, 8'h70);
        epreq++;
        op(OP_PROG_EXEC, 17'h0_0002, 7, 1);
        op(OP_PAGE_READ, 17'h0_0002, 7, 1);
        op(OP_PROG_EXEC, 17'h0_0002, 2, 1);
        op(OP_PROG_EXEC, 17'h0_001E, 2, 1);
        op(OP_ERASE, 17'h0_0003, 3, 1);
        setf(FEAT_CFG_ADDR, 8'hD0, 8'hF0);
        op(OP_PROG_EXEC, 17'h0_0003, 5, 1);
        setf(FEAT_CFG_ADDR, 8'h50, 8'h70);
        op(OP_PROG_EXEC, 17'h0_0003, 2, 1);
        ex(1, 8'h30);
        frame({24'h00_0000, OP_RESET}, 8);
        hold_n <= 1'b0;
        fork
            frame({OP_LOAD_X4, 24'h00_0000}, 32);
            begin
                #2000;
                ex(13, 8'h01);
                -> chk_ev;
                #2600;
                ex(13, 8'h00);
                -> chk_ev;
            end
        join
        setf(FEAT_CFG_ADDR, 8'h11, 8'h31);
        ex(13, 8'h00);
        ex(14, 8'h31);
        frame({8'h00, OP_GET_FEAT, FEAT_CFG_ADDR, 8'h00}, 24);
        results();
    end
endmodule
